// >>> pll_programming_and_lock_control_test.sv
`timescale 1ns/100ps
module pll_programming_and_lock_control_test import pplc_pkg::*;;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, lockDetect = 1'b0, stopMode = 1'b0;
   logic breakState = 1'b0, breakClearEnable = 1'b0, oscRunInStop = 1'b0;
   logic oscClkIn = 1'b0, vcoClkIn = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
   logic hreadyout, hresp, baseClockOut, generatorIrq;
   pplc_clk_ctrl_t clkCtrl;
   int bad_count = 0, samples_checked = 0, tick = 0;
   logic [7:0] regIdx [4] = '{IDX_FB_HIGH, IDX_FB_LOW, IDX_VCO_RANGE, IDX_REF_DIV};
   logic [7:0] regDef [4] = '{8'h00, 8'h40, 8'h40, 8'h01};

   always #12.5 ref_clk = ~ref_clk;

   // Source clocks of periods 4 and 6 cycles, so the halved outputs differ
   always @(posedge ref_clk) begin
      tick <= tick + 1;
      oscClkIn <= (tick % 4) >= 2;
      vcoClkIn <= (tick % 6) >= 3;
   end

   pplc_loop_control uut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .lockDetect, .acqDetect(1'b1), .oscClkIn, .vcoClkIn, .stopMode, .breakState,
      .breakClearEnable, .oscRunInStop, .baseClockOut, .generatorIrq, .clkCtrl);

   // *****************************
   // Bus and comparison tasks
   // *****************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic chk(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      check(rv, {24'h0, e});
   endtask

   // Counts base clock changes over 48 cycles, after the switch stasis
   task automatic toggles(input int e);
      int c;
      logic last;
      c = 0;
      repeat (12) @(posedge ref_clk);
      last = baseClockOut;
      repeat (48) begin
         @(posedge ref_clk);
         if (baseClockOut !== last) c++;
         last = baseClockOut;
      end
      check(c, e);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge ref_clk);
      bad_count++;
      finish_test;
   end

   // *****************************
   // Test sequence
   // *****************************
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) chk(regIdx[i], regDef[i]);
      for (int i = 0; i < 4; i++) wr(regIdx[i], 8'h0a);
      for (int i = 0; i < 4; i++) chk(regIdx[i], regDef[i]);
      wr(8'h10, 8'hff);
      chk(8'h10, 8'h00);
      wr(IDX_LOOP_CTRL, 8'h00);
      wr(IDX_FB_HIGH, 8'h0a);
      wr(IDX_FB_LOW, 8'hbc);
      wr(IDX_REF_DIV, 8'h00);
      wr(IDX_VCO_RANGE, 8'h00);
      chk(IDX_FB_LOW, 8'hbc);
      check({20'h0, clkCtrl.feedbackDivisor}, 32'habc);
      check({28'h0, clkCtrl.refDivisor}, 32'h1);
      wr(IDX_FB_HIGH, 8'h00);
      wr(IDX_FB_LOW, 8'h00);
      repeat (2) @(posedge ref_clk);
      check({20'h0, clkCtrl.feedbackDivisor}, 32'h1);
      wr(IDX_LOOP_CTRL, 8'h20);
      wr(IDX_LOOP_CTRL, 8'h30);
      chk(IDX_LOOP_CTRL, 8'h20);
      check({31'h0, clkCtrl.loopActive}, 32'h0);
      wr(IDX_LOOP_CTRL, 8'h00);
      wr(IDX_LOOP_CTRL, 8'h10);
      chk(IDX_LOOP_CTRL, 8'h00);
      wr(IDX_VCO_RANGE, 8'h40);
      wr(IDX_LOOP_CTRL, 8'h20);
      toggles(12);
      wr(IDX_LOOP_CTRL, 8'h30);
      toggles(8);
      wr(IDX_LOOP_CTRL, 8'h10);
      chk(IDX_LOOP_CTRL, 8'h30);
      oscRunInStop <= 1'b1;
      stopMode <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check({30'h0, clkCtrl.oscEnable, clkCtrl.loopActive}, 32'h2);
      toggles(12);
      stopMode <= 1'b0;
      chk(IDX_LOOP_CTRL, 8'h20);
      oscRunInStop <= 1'b0;
      stopMode <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check({29'h0, clkCtrl.oscEnable, clkCtrl.loopActive, baseClockOut}, 32'h0);
      stopMode <= 1'b0;
      lockDetect <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check({31'h0, generatorIrq}, 32'h0);
      chk(IDX_LOOP_CTRL, 8'h20);
      lockDetect <= 1'b0;
      wr(IDX_BW_CTRL, 8'h80);
      repeat (8) @(posedge ref_clk);
      bus(1'b0, IDX_LOOP_CTRL, 8'h00);
      wr(IDX_LOOP_CTRL, 8'ha0);
      lockDetect <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check({31'h0, generatorIrq}, 32'h1);
      chk(IDX_LOOP_CTRL, 8'he0);
      chk(IDX_LOOP_CTRL, 8'ha0);
      check({31'h0, generatorIrq}, 32'h0);
      chk(IDX_BW_CTRL, 8'he0);
      wr(IDX_LOOP_CTRL, 8'h20);
      lockDetect <= 1'b0;
      repeat (8) @(posedge ref_clk);
      check({31'h0, generatorIrq}, 32'h0);
      chk(IDX_LOOP_CTRL, 8'h60);
      breakState <= 1'b1;
      lockDetect <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(IDX_LOOP_CTRL, 8'h60);
      wr(IDX_LOOP_CTRL, 8'h20);
      chk(IDX_LOOP_CTRL, 8'h60);
      breakClearEnable <= 1'b1;
      chk(IDX_LOOP_CTRL, 8'h60);
      chk(IDX_LOOP_CTRL, 8'h20);
      breakState <= 1'b0;
      breakClearEnable <= 1'b0;
      chk(IDX_LOOP_CTRL, 8'h20);
      lockDetect <= 1'b0;
      repeat (8) @(posedge ref_clk);
      wr(IDX_BW_CTRL, 8'h00);
      chk(IDX_LOOP_CTRL, 8'h20);
      finish_test;
   end
endmodule // pll_programming_and_lock_control_test

// >>> pplc_clock_halver.sv
`timescale 1ns/100ps
module pplc_clock_halver import pplc_pkg::*; (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic oscSample,
   input wire logic vcoSample,
   input wire logic selVco,
   input wire logic run,
   output logic baseOut
);

   logic oscPrev;
   logic vcoPrev;
   logic selPrev;
   logic [1:0] holdCnt;
   logic srcRise;

   always_comb begin
      srcRise = selVco ? (vcoSample & ~vcoPrev) : (oscSample & ~oscPrev);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oscPrev <= 1'b0;
         vcoPrev <= 1'b0;
         selPrev <= 1'b0;
      end else begin
         oscPrev <= oscSample;
         vcoPrev <= vcoSample;
         selPrev <= selVco;
      end
   end

   // ************************************************************
   // Stasis while the source changes, so no runt pulse escapes
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         holdCnt <= 2'h0;
      end else if (selPrev != selVco) begin
         holdCnt <= SWITCH_HOLD_CYCLES;
      end else if (holdCnt != 2'h0) begin
         holdCnt <= holdCnt - 2'h1;
      end
   end

   // Toggling on each source rising edge gives half rate, even duty
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         baseOut <= 1'b0;
      end else if (!run) begin
         baseOut <= 1'b0;
      end else if (srcRise && holdCnt == 2'h0 && selPrev == selVco) begin
         baseOut <= ~baseOut;
      end
   end

endmodule // pplc_clock_halver

// >>> pplc_lock_monitor.sv
`timescale 1ns/100ps
module pplc_lock_monitor import pplc_pkg::*; (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic lockIn,
   input wire logic watchEn,
   output logic lockState,
   output logic lockToggle
);

   // ************************************************************
   // Lock transition detector
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lockState <= 1'b0;
      end else begin
         lockState <= lockIn;
      end
   end

   // Both entry into and exit from lock count
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lockToggle <= 1'b0;
      end else begin
         lockToggle <= watchEn & (lockIn != lockState);
      end
   end

endmodule // pplc_lock_monitor

// >>> pplc_loop_control.sv
// Contract
// - Feedback multiplier zero configures like one; the register still reads back zero.
// - Reset loads feedback multiplier with 040 hex, factor sixty-four.
// - Feedback multiplier writes ignored while loop power is on.
// - Range multiplier writes blocked while loop power is on.
// - Range multiplier zero disables loop and forces base select to zero.
// - Base select cannot be set while range multiplier is all zero.
// - Reset loads range multiplier with 40 hex.
// - Reference divider writes blocked while loop power is on.
// - Reference divider zero configures like one.
// - Reset sets reference divider to one.
// - Auto bandwidth: each lock change raises interrupt when enabled.
// - Lock change sets the flag whatever the enable.
// - Manual bandwidth: no interrupt, flag reads zero.
// - Wait mode leaves the generator unchanged.
// - Stop with oscillator off: oscillator, loop off, outputs low.
// - Stop clears base select; oscillator half clock stays after wakeup.
// - Stop with oscillator kept: loop off, oscillator clock still supplied.
// - Break with clear enable: read clears flag, stays clear.
// - Break without clear enable: flag untouched by control accesses.
// - Outside break, any loop control read clears the flag.
// - Base select set refused while loop power is clear.
// - Base clock is half the selected source, even duty.
`timescale 1ns/100ps
module pplc_loop_control import pplc_pkg::*; (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic lockDetect,
   input wire logic acqDetect,
   input wire logic oscClkIn,
   input wire logic vcoClkIn,
   input wire logic stopMode,
   input wire logic breakState,
   input wire logic breakClearEnable,
   input wire logic oscRunInStop,
   output logic baseClockOut,
   output logic generatorIrq,
   output pplc_clk_ctrl_t clkCtrl
);

   // ************************************************************
   // State
   // ************************************************************
   logic ieReg;
   logic flagReg;
   logic powerReg;
   logic selectReg;
   logic [1:0] preReg;
   logic [1:0] vprReg;
   logic autoReg;
   logic acqReg;
   logic [11:0] fbMulReg;
   logic [7:0] rangeReg;
   logic [3:0] refDivReg;
   logic wrPend;
   logic rdPend;
   logic [7:0] wrIdx;
   logic [7:0] rdIdx;
   logic lockState;
   logic lockToggle;
   logic oscRun;
   logic rangeZero;
   logic addrTaken;
   logic wrDo;
   logic [7:0] wrByte;
   logic flagClear;
   logic [7:0] readByte;
   pplc_clk_ctrl_t clkCtrl_next;
   logic [11:0] refDivEff;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Word size only; the master issues nothing else, hsize is not checked
   always_comb begin
      addrTaken = hsel & htrans[1] & hready;
      wrDo = wrPend;
      wrByte = hwdata[7:0];
      oscRun = ~(stopMode & ~oscRunInStop);
      rangeZero = (rangeReg == 8'h00);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend <= 1'b0;
         wrIdx <= 8'h00;
      end else begin
         wrPend <= addrTaken & hwrite;
         if (addrTaken && hwrite) begin
            wrIdx <= haddr[9:2];
         end
      end
   end

   // A read gets one wait state so a write just before it is seen
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdPend <= 1'b0;
         rdIdx <= 8'h00;
      end else begin
         rdPend <= addrTaken & ~hwrite & ~rdPend;
         if (addrTaken && !hwrite) begin
            rdIdx <= haddr[9:2];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= ~(addrTaken & ~hwrite & ~rdPend);
      end
   end

   // Every access, refused or not, ends OKAY
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      readByte = 8'h00;
      case (rdIdx)
         IDX_LOOP_CTRL: begin
            readByte[LC_IE_BIT] = ieReg & autoReg;
            readByte[LC_FLAG_BIT] = flagReg & autoReg;
            readByte[LC_POWER_BIT] = powerReg;
            readByte[LC_SELECT_BIT] = selectReg;
            readByte[LC_PRE_LSB +: 2] = preReg;
            readByte[LC_VPR_LSB +: 2] = vprReg;
         end
         IDX_BW_CTRL: begin
            readByte[BW_AUTO_BIT] = autoReg;
            readByte[BW_LOCK_BIT] = autoReg & lockState;
            readByte[BW_ACQ_BIT] = autoReg ? acqDetect : acqReg;
         end
         IDX_FB_HIGH: readByte = {4'h0, fbMulReg[11:8]};
         IDX_FB_LOW: readByte = fbMulReg[7:0];
         IDX_VCO_RANGE: readByte = rangeReg;
         IDX_REF_DIV: readByte = {4'h0, refDivReg};
         default: readByte = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= 32'h00000000;
      end else if (rdPend) begin
         hrdata <= {24'h000000, readByte};
      end
   end

   // Read of loop control clears the flag, unless break protects it
   always_comb begin
      flagClear = rdPend & (rdIdx == IDX_LOOP_CTRL) & (~breakState | breakClearEnable);
   end

   // ************************************************************
   // Loop control register
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ieReg <= 1'b0;
      end else if (wrDo && wrIdx == IDX_LOOP_CTRL && autoReg) begin
         ieReg <= wrByte[LC_IE_BIT];
      end
   end

   // Power cannot drop while the loop clock drives the base clock
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         powerReg <= RST_LOOP_POWER;
      end else if (wrDo && wrIdx == IDX_LOOP_CTRL) begin
         powerReg <= wrByte[LC_POWER_BIT] | selectReg;
      end
   end

   // Setting select needs power already on: two writes from off
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         selectReg <= 1'b0;
      end else if (stopMode) begin
         selectReg <= 1'b0;
      end else if (rangeZero) begin
         selectReg <= 1'b0;
      end else if (wrDo && wrIdx == IDX_LOOP_CTRL) begin
         selectReg <= wrByte[LC_SELECT_BIT] & powerReg;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         preReg <= RST_TWO_BITS;
         vprReg <= RST_TWO_BITS;
      end else if (wrDo && wrIdx == IDX_LOOP_CTRL && !powerReg) begin
         preReg <= wrByte[LC_PRE_LSB +: 2];
         vprReg <= wrByte[LC_VPR_LSB +: 2];
      end
   end

   // A lock change in the same cycle as a clearing read wins
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flagReg <= 1'b0;
      end else if (lockToggle) begin
         flagReg <= 1'b1;
      end else if (flagClear) begin
         flagReg <= 1'b0;
      end
   end

   // ************************************************************
   // Bandwidth control register
   // ************************************************************
   // Manual acquisition value is kept while auto runs
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         autoReg <= 1'b0;
         acqReg <= 1'b0;
      end else if (wrDo && wrIdx == IDX_BW_CTRL) begin
         autoReg <= wrByte[BW_AUTO_BIT];
         if (!autoReg) begin
            acqReg <= wrByte[BW_ACQ_BIT];
         end
      end
   end

   // ************************************************************
   // Programming registers, frozen while the loop is powered
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fbMulReg <= RST_FB_MULT;
      end else if (wrDo && !powerReg) begin
         if (wrIdx == IDX_FB_HIGH) begin
            fbMulReg[11:8] <= wrByte[3:0];
         end else if (wrIdx == IDX_FB_LOW) begin
            fbMulReg[7:0] <= wrByte;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rangeReg <= RST_VCO_RANGE;
      end else if (wrDo && !powerReg && wrIdx == IDX_VCO_RANGE) begin
         rangeReg <= wrByte;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         refDivReg <= RST_REF_DIV;
      end else if (wrDo && !powerReg && wrIdx == IDX_REF_DIV) begin
         refDivReg <= wrByte[3:0];
      end
   end

   // ************************************************************
   // Settings to the analog loop
   // ************************************************************
   // Four-bit divider widened so the shared zero-as-one function serves it
   always_comb begin
      refDivEff = pplc_eff_div({8'h00, refDivReg});
   end

   // Only stop and software settings touch the generator, wait does not
   always_comb begin
      clkCtrl_next.loopActive = powerReg & ~rangeZero & ~stopMode;
      clkCtrl_next.oscEnable = oscRun;
      clkCtrl_next.baseSelect = selectReg;
      clkCtrl_next.acqTrack = acqReg;
      clkCtrl_next.prescale = preReg;
      clkCtrl_next.rangePower = vprReg;
      clkCtrl_next.feedbackDivisor = pplc_eff_div(fbMulReg);
      clkCtrl_next.rangeMult = rangeReg;
      clkCtrl_next.refDivisor = refDivEff[3:0];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clkCtrl <= '0;
      end else begin
         clkCtrl <= clkCtrl_next;
      end
   end

   // ************************************************************
   // Interrupt line
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         generatorIrq <= 1'b0;
      end else begin
         generatorIrq <= flagReg & ieReg & autoReg & oscRun;
      end
   end

   // ************************************************************
   // Lock watch and base clock
   // ************************************************************
   // Lock is only watched in auto mode with the loop running
   pplc_lock_monitor u_lock (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .lockIn(lockDetect),
      .watchEn(autoReg & clkCtrl_next.loopActive),
      .lockState(lockState),
      .lockToggle(lockToggle)
   );

   // Loop clock may be selected while unlocked; software must check lock
   pplc_clock_halver u_base (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .oscSample(oscClkIn),
      .vcoSample(vcoClkIn),
      .selVco(selectReg),
      .run(oscRun),
      .baseOut(baseClockOut)
   );

endmodule // pplc_loop_control

// >>> pplc_loop_control_asserts.sv
`timescale 1ns/100ps
module pplc_loop_control_asserts import pplc_pkg::*; (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic stopMode,
   input wire logic oscRunInStop,
   input wire logic baseClockOut,
   input wire logic generatorIrq,
   input wire pplc_clk_ctrl_t clkCtrl
);
   // *****************************
   // Checks on the bus and settings
   // *****************************
   default clocking dcb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   logic taken;
   assign taken = hsel && htrans[1] && hready;

   bus_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   write_nowait_a: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   // Guarded by the past reset because the settings lag the registers by one cycle
   div_nonzero_a: assert property (!$past(sys_rst) |->
      clkCtrl.feedbackDivisor != 12'h000 && clkCtrl.refDivisor != 4'h0)
      else $error("zero divisor reached the loop");
   reset_defaults_a: assert property ($past(sys_rst) |=>
      clkCtrl.feedbackDivisor == 12'h040 && clkCtrl.rangeMult == 8'h40
      && clkCtrl.refDivisor == 4'h1)
      else $error("settings not at defaults after reset");
   range_zero_a: assert property (clkCtrl.rangeMult == 8'h00 |->
      !clkCtrl.loopActive && !clkCtrl.baseSelect)
      else $error("zero range left loop or select on");
   select_guard_a: assert property ($rose(clkCtrl.baseSelect) |->
      $past(clkCtrl.loopActive))
      else $error("select set with loop off");
   protect_hold_a: assert property (clkCtrl.loopActive |=>
      $stable(clkCtrl.feedbackDivisor) && $stable(clkCtrl.rangeMult)
      && $stable(clkCtrl.refDivisor))
      else $error("protected setting changed while powered");
   stop_dark_a: assert property ((stopMode && !oscRunInStop)[*2] |=>
      !generatorIrq && !baseClockOut && !clkCtrl.oscEnable && !clkCtrl.loopActive)
      else $error("outputs alive in full stop");
   stop_osc_a: assert property ((stopMode && oscRunInStop)[*2] |=>
      clkCtrl.oscEnable && !clkCtrl.loopActive)
      else $error("stop with oscillator kept is wrong");
   stop_select_a: assert property (stopMode |-> ##2 !clkCtrl.baseSelect)
      else $error("select kept in stop");
   base_half_a: assert property ($changed(baseClockOut) |=> $stable(baseClockOut))
      else $error("base clock toggled on adjacent cycles");
endmodule // pplc_loop_control_asserts

bind pplc_loop_control pplc_loop_control_asserts u_chk (.ref_clk, .sys_rst, .hsel,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .stopMode, .oscRunInStop,
   .baseClockOut, .generatorIrq, .clkCtrl);

// >>> pplc_pkg.sv
package pplc_pkg;

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_LOOP_CTRL = 8'h36;
   localparam logic [7:0] IDX_BW_CTRL = 8'h37;
   localparam logic [7:0] IDX_FB_HIGH = 8'h38;
   localparam logic [7:0] IDX_FB_LOW = 8'h39;
   localparam logic [7:0] IDX_VCO_RANGE = 8'h3a;
   localparam logic [7:0] IDX_REF_DIV = 8'h3b;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LC_IE_BIT = 7;
   localparam int LC_FLAG_BIT = 6;
   localparam int LC_POWER_BIT = 5;
   localparam int LC_SELECT_BIT = 4;
   localparam int LC_PRE_LSB = 2;
   localparam int LC_VPR_LSB = 0;
   localparam int BW_AUTO_BIT = 7;
   localparam int BW_LOCK_BIT = 6;
   localparam int BW_ACQ_BIT = 5;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [11:0] RST_FB_MULT = 12'h040;
   localparam logic [7:0] RST_VCO_RANGE = 8'h40;
   localparam logic [3:0] RST_REF_DIV = 4'h1;
   localparam logic RST_LOOP_POWER = 1'b1;
   localparam logic [1:0] RST_TWO_BITS = 2'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   // Stasis on the base clock after a source change, in ref_clk cycles
   localparam logic [1:0] SWITCH_HOLD_CYCLES = 2'h3;

   // ************************************************************
   // Carrier of the programmed clock generator settings
   // ************************************************************
   typedef struct packed {
      logic loopActive;
      logic oscEnable;
      logic baseSelect;
      logic acqTrack;
      logic [1:0] prescale;
      logic [1:0] rangePower;
      logic [11:0] feedbackDivisor;
      logic [7:0] rangeMult;
      logic [3:0] refDivisor;
   } pplc_clk_ctrl_t;

   // Zero divides like one
   function automatic logic [11:0] pplc_eff_div(input logic [11:0] v);
      pplc_eff_div = (v == 12'h000) ? 12'h001 : v;
   endfunction

endpackage
